// ---- can_msg_pkg.sv ----
// Constants and types for the message request, status and prescaler block
package can_msg_pkg;
  localparam int          OBJ_COUNT        = 16;
  localparam int          OBJ_W            = 4;
  localparam int          DIV_W            = 6;
  localparam int          TS1_W            = 4;
  localparam int          TS2_W            = 3;
  localparam int          TS1_LSB          = 0;
  localparam int          TS2_LSB          = 4;
  localparam int          MODE_INIT_BIT    = 0;
  localparam int          IRQ_EN_RX_BIT    = 0;
  localparam int          CORE_CLK_HZ      = 20000000;
  localparam int          OSC_PER_SYS_STEP = 2;
  localparam logic [4:0]  BIT_SEG_EXTRA    = 5'h02;
  localparam logic [1:0]  IRQ_HOLD_TICKS   = 2'h2;
  localparam logic [5:0]  IDX_BIT_LEN      = 6'h00;
  localparam logic [5:0]  IDX_PRESCALER    = 6'h03;
  localparam logic [5:0]  IDX_RX_READY_LO  = 6'h04;
  localparam logic [5:0]  IDX_RX_READY_HI  = 6'h05;
  localparam logic [5:0]  IDX_RX_MASK_LO   = 6'h06;
  localparam logic [5:0]  IDX_RX_MASK_HI   = 6'h07;
  localparam logic [5:0]  IDX_TX_SET_LO    = 6'h08;
  localparam logic [5:0]  IDX_TX_SET_HI    = 6'h09;
  localparam logic [5:0]  IDX_IRQ_ENABLE   = 6'h0A;
  localparam logic [5:0]  IDX_TX_CANCEL_LO = 6'h18;
  localparam logic [5:0]  IDX_TX_CANCEL_HI = 6'h19;
  localparam logic [5:0]  IDX_REMOTE_LO    = 6'h1A;
  localparam logic [5:0]  IDX_REMOTE_HI    = 6'h1B;
  localparam logic [5:0]  IDX_MODE         = 6'h20;
  localparam logic [5:0]  DIV_RESET        = 6'h00;
  localparam logic [7:0]  BIT_LEN_RESET    = 8'h00;
  localparam logic [7:0]  MODE_RESET       = 8'h01;
  localparam logic [15:0] OBJ_RESET        = 16'h0000;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_type;
endpackage : can_msg_pkg

// ---- can_msg_request_status_and_prescaler.sv ----
// Message request, receive status and baud prescaler block with Avalon-MM slave
`timescale 1ns/1ns
module can_msg_request_status_and_prescaler
  import can_msg_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [3:0]       avs_byteenable_i,
  input  wire logic [31:0]      avs_writedata_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // Protocol engine events
  input  wire logic             rx_store_i,
  input  wire logic [OBJ_W-1:0] rx_obj_i,
  input  wire logic             remote_rx_i,
  input  wire logic [OBJ_W-1:0] remote_obj_i,
  input  wire logic             tx_done_i,
  // Transmit job, timing and interrupt
  output logic                  tx_start_o,
  output logic      [OBJ_W-1:0] tx_obj_o,
  output logic                  tx_busy_o,
  output logic                  sys_tick_o,
  output logic                  bit_tick_o,
  output logic                  irq_o
);

  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [DIV_W-1:0]     clock_divider_value_q;
  logic [7:0]           bit_len_q;
  logic [7:0]           mode_q;
  logic                 global_rx_irq_enable_q;
  logic [15:0]          rx_ready_q;
  logic [15:0]          rx_mask_q;
  logic [15:0]          tx_req_q;
  logic [15:0]          remote_q;
  tx_state_type         tx_state_q;
  logic [OBJ_W-1:0]     cur_obj_q;
  logic                 tx_start_q;
  logic [6:0]           sys_cnt_q;
  logic [4:0]           bit_cnt_q;
  logic                 sys_tick_q;
  logic                 bit_tick_q;
  logic                 irq_q;
  logic [1:0]           hold_q;
  logic [5:0]           idx;
  logic [7:0]           wbyte;
  logic                 wr_acc;
  logic                 hi_sel;
  logic                 init_mode_bit;
  logic [15:0]          sw_lane;
  logic [15:0]          rx_set;
  logic [15:0]          rx_clr;
  logic [15:0]          tx_set;
  logic [15:0]          tx_cancel;
  logic [15:0]          tx_done_clr;
  logic [15:0]          rem_set;
  logic [31:0]          rd_val;
  logic                 rx_irq_req;
  logic [6:0]           sys_end;
  logic [4:0]           bit_end;

  function automatic logic [15:0] onehot16(input logic [OBJ_W-1:0] obj);
    onehot16 = 16'h0001 << obj;
  endfunction : onehot16

  function automatic logic [15:0] lane16(input logic [7:0] b, input logic hi);
    lane16 = hi ? {b, 8'h00} : {8'h00, b};
  endfunction : lane16

  function automatic logic [OBJ_W-1:0] highest16(input logic [15:0] v);
    highest16 = '0;
    for (int i = 0; i < OBJ_COUNT; i++) begin
      if (v[i]) begin
        highest16 = OBJ_W'(i);
      end
    end
  endfunction : highest16

  // Bus decode
  assign idx           = avs_address_i[7:2];
  assign wbyte         = avs_writedata_i[7:0];
  assign hi_sel        = idx[0];
  assign wr_acc        = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign init_mode_bit = mode_q[MODE_INIT_BIT];
  assign sw_lane       = lane16(wbyte, hi_sel);

  // Flag update terms
  assign rx_set      = rx_store_i ? onehot16(rx_obj_i) : OBJ_RESET;
  assign rx_clr      = (wr_acc && (idx == IDX_RX_READY_LO || idx == IDX_RX_READY_HI))
                       ? lane16(~wbyte, hi_sel) : OBJ_RESET;
  assign tx_set      = (wr_acc && (idx == IDX_TX_SET_LO || idx == IDX_TX_SET_HI))
                       ? sw_lane : OBJ_RESET;
  assign tx_cancel   = ((wr_acc && (idx == IDX_TX_CANCEL_LO || idx == IDX_TX_CANCEL_HI))
                       ? sw_lane : OBJ_RESET)
                       & ~((tx_state_q == TX_SEND) ? onehot16(cur_obj_q) : OBJ_RESET);
  assign tx_done_clr = (tx_state_q == TX_SEND && tx_done_i) ? onehot16(cur_obj_q) : OBJ_RESET;
  assign rem_set     = remote_rx_i ? onehot16(remote_obj_i) : OBJ_RESET;

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_BIT_LEN:     rd_val[7:0] = bit_len_q;
      IDX_RX_READY_LO: rd_val[7:0] = rx_ready_q[7:0];
      IDX_RX_READY_HI: rd_val[7:0] = rx_ready_q[15:8];
      IDX_RX_MASK_LO:  rd_val[7:0] = rx_mask_q[7:0];
      IDX_RX_MASK_HI:  rd_val[7:0] = rx_mask_q[15:8];
      IDX_TX_SET_LO:   rd_val[7:0] = tx_req_q[7:0];
      IDX_TX_SET_HI:   rd_val[7:0] = tx_req_q[15:8];
      IDX_IRQ_ENABLE:  rd_val[IRQ_EN_RX_BIT] = global_rx_irq_enable_q;
      IDX_REMOTE_LO:   rd_val[7:0] = remote_q[7:0];
      IDX_REMOTE_HI:   rd_val[7:0] = remote_q[15:8];
      IDX_MODE:        rd_val[7:0] = mode_q;
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, then accept
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= rd_val;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_divider_value_q  <= DIV_RESET;
      bit_len_q              <= BIT_LEN_RESET;
      mode_q                 <= MODE_RESET;
      global_rx_irq_enable_q <= 1'b0;
      rx_mask_q              <= OBJ_RESET;
    end else if (wr_acc) begin
      if (idx == IDX_PRESCALER && init_mode_bit) begin
        clock_divider_value_q <= wbyte[DIV_W-1:0];
      end
      if (idx == IDX_BIT_LEN && init_mode_bit) begin
        bit_len_q <= wbyte;
      end
      if (idx == IDX_MODE) begin
        mode_q <= wbyte;
      end
      if (idx == IDX_IRQ_ENABLE) begin
        global_rx_irq_enable_q <= wbyte[IRQ_EN_RX_BIT];
      end
      if (idx == IDX_RX_MASK_LO) begin
        rx_mask_q[7:0] <= wbyte;
      end
      if (idx == IDX_RX_MASK_HI) begin
        rx_mask_q[15:8] <= wbyte;
      end
    end
  end

  // Object flags, set wins over clear (hardware set for rx_ready_q and remote_q, software set for tx_req_q)
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ready_q <= OBJ_RESET;
      tx_req_q   <= OBJ_RESET;
      remote_q   <= OBJ_RESET;
    end else begin
      rx_ready_q <= (rx_ready_q & ~rx_clr) | rx_set;
      tx_req_q   <= (tx_req_q & ~tx_cancel & ~tx_done_clr) | tx_set;
      remote_q   <= (remote_q & ~tx_done_clr) | rem_set;
    end
  end

  // Transmit job sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_q <= TX_IDLE;
      cur_obj_q  <= '0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      case (tx_state_q)
        TX_IDLE: begin
          if (|tx_req_q) begin
            cur_obj_q  <= highest16(tx_req_q);
            tx_start_q <= 1'b1;
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_done_i) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // System step and bit time dividers
  assign sys_end = {clock_divider_value_q, 1'b1};
  assign bit_end = 5'(bit_len_q[TS1_LSB +: TS1_W]) + 5'(bit_len_q[TS2_LSB +: TS2_W]) + BIT_SEG_EXTRA;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_cnt_q  <= 7'h00;
      sys_tick_q <= 1'b0;
    end else if (sys_cnt_q >= sys_end) begin
      sys_cnt_q  <= 7'h00;
      sys_tick_q <= 1'b1;
    end else begin
      sys_cnt_q  <= sys_cnt_q + 7'h01;
      sys_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q  <= 5'h00;
      bit_tick_q <= 1'b0;
    end else begin
      bit_tick_q <= 1'b0;
      if (sys_tick_q) begin
        if (bit_cnt_q >= bit_end) begin
          bit_cnt_q  <= 5'h00;
          bit_tick_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end

  // Receive interrupt with minimum hold
  assign rx_irq_req = global_rx_irq_enable_q && |(rx_ready_q & rx_mask_q);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q  <= 1'b0;
      hold_q <= 2'h0;
    end else if (!irq_q) begin
      irq_q  <= rx_irq_req;
      hold_q <= 2'h0;
    end else if (hold_q != IRQ_HOLD_TICKS) begin
      if (bit_tick_q) begin
        hold_q <= hold_q + 2'h1;
      end
    end else if (!rx_irq_req) begin
      irq_q <= 1'b0;
    end
  end

  // Outputs
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign tx_start_o        = tx_start_q;
  assign tx_obj_o          = cur_obj_q;
  assign tx_busy_o         = (tx_state_q == TX_SEND);
  assign sys_tick_o        = sys_tick_q;
  assign bit_tick_o        = bit_tick_q;
  assign irq_o             = irq_q;

  // Checks
  chk_prescaler_locked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acc && idx == IDX_PRESCALER && !init_mode_bit) |=> $stable(clock_divider_value_q))
    else $error("prescaler changed outside init mode");
  chk_rx_ready_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_store_i |=> rx_ready_q[$past(rx_obj_i)])
    else $error("receive-ready not set after store");
  chk_rx_ready_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(|rx_ready_q) |-> $past(wr_acc) && !$past(rx_store_i))
    else $error("receive-ready cleared without software write");
  chk_irq_gated: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(irq_o) |-> $past(global_rx_irq_enable_q) && $past(|(rx_ready_q & rx_mask_q)))
    else $error("interrupt raised without enabled request");
  chk_irq_raise: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!irq_q && rx_irq_req) |=> irq_o)
    else $error("interrupt not raised");
  chk_irq_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(irq_o) |-> $past(hold_q) == IRQ_HOLD_TICKS && !$past(rx_irq_req))
    else $error("interrupt dropped early");
  chk_tx_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_set != OBJ_RESET) |=> ((tx_req_q & $past(tx_set)) == $past(tx_set)))
    else $error("transmit request not set");
  chk_tx_order: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(tx_busy_o) |-> tx_start_o && tx_obj_o == highest16($past(tx_req_q)))
    else $error("transmit order not highest first");
  chk_tx_done: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_busy_o && tx_done_i && tx_set == OBJ_RESET) |=> !tx_req_q[$past(cur_obj_q)] && !tx_busy_o)
    else $error("request not cleared after transmission");
  chk_cancel_busy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_busy_o && !tx_done_i) |=> tx_req_q[$past(cur_obj_q)] || !$past(tx_req_q[cur_obj_q]))
    else $error("active transmission cancelled");
  chk_remote_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_busy_o && tx_done_i && !remote_rx_i) |=> !remote_q[$past(cur_obj_q)])
    else $error("remote pending not cleared");
  chk_bit_ticks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bit_tick_o |-> $past(sys_tick_q))
    else $error("bit tick not on system step");
  chk_ready_clear_lo: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acc && idx == IDX_RX_READY_LO && !rx_store_i) |=> rx_ready_q[7:0] == ($past(rx_ready_q[7:0]) & $past(wbyte)))
    else $error("low receive-ready write not applied as clear-on-zero");
  chk_ready_clear_hi: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acc && idx == IDX_RX_READY_HI && !rx_store_i) |=> rx_ready_q[15:8] == ($past(rx_ready_q[15:8]) & $past(wbyte)))
    else $error("high receive-ready write not applied as clear-on-zero");
  chk_cancel_drops: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_cancel != OBJ_RESET && tx_set == OBJ_RESET) |=> (tx_req_q & $past(tx_cancel)) == OBJ_RESET)
    else $error("cancelled request still pending");
  chk_remote_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    remote_rx_i |=> remote_q[$past(remote_obj_i)])
    else $error("remote pending not set after remote frame");
  chk_wo_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (avs_read_i && wait_q && (idx == IDX_PRESCALER || idx == IDX_TX_CANCEL_LO || idx == IDX_TX_CANCEL_HI))
    |=> avs_readdata_o == 32'h0000_0000)
    else $error("write-only register returned data");
  chk_irq_enable_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!global_rx_irq_enable_q && !irq_q) |=> !irq_o)
    else $error("interrupt raised while receive interrupts disabled");

endmodule : can_msg_request_status_and_prescaler

// ---- can_engine_model.sv ----
// Behavioural protocol engine that answers transmit jobs
`timescale 1ns/1ns
module can_engine_model
  import can_msg_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Job interface
  input  wire logic             tx_start_i,
  input  wire logic [OBJ_W-1:0] tx_obj_i,
  input  wire logic [7:0]       delay_i,
  output logic                  tx_done_o,
  output logic      [15:0]      hist_o
);
  logic       act_q;
  logic [7:0] cnt_q;
  // Finishes each job delay_i + 1 cycles after its start and logs the object sent
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_q     <= 1'b0;
      cnt_q     <= 8'h00;
      tx_done_o <= 1'b0;
      hist_o    <= 16'h0000;
    end else begin
      tx_done_o <= 1'b0;
      if (tx_start_i) begin
        act_q  <= 1'b1;
        cnt_q  <= delay_i;
        hist_o <= {hist_o[11:0], tx_obj_i};
      end else if (act_q && cnt_q == 8'h00) begin
        tx_done_o <= 1'b1;
        act_q     <= 1'b0;
      end else if (act_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : can_engine_model

// ---- can_msg_request_status_and_prescaler_bench.sv ----
// Self-checking bench for the message request, status and prescaler block
`timescale 1ns/1ns
module can_msg_request_status_and_prescaler_bench
  import can_msg_pkg::*;
;
  logic             clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rx_st = 1'b0, rem = 1'b0;
  logic [7:0]       adr = 8'h00, dly = 8'h00;
  logic [3:0]       ben = 4'h1;
  logic [31:0]      wdat = 32'h0, rdat;
  logic [OBJ_W-1:0] rx_obj = 4'h0, rem_obj = 4'h0, tx_obj;
  logic             wreq, done, start, busy, stick, btick, irq;
  logic [15:0]      hist;
  logic [7:0]       q;
  int               n_errors = 0, comparisons = 0;
  localparam logic [22:0] ROWS [15] = '{
    {1'b0, IDX_MODE, 8'h00, 8'h01}, {1'b1, IDX_RX_MASK_LO, 8'hA5, 8'h00},
    {1'b0, IDX_RX_MASK_LO, 8'h00, 8'hA5}, {1'b1, IDX_RX_MASK_HI, 8'h3C, 8'h00},
    {1'b0, IDX_RX_MASK_HI, 8'h00, 8'h3C}, {1'b1, IDX_PRESCALER, 8'h02, 8'h00},
    {1'b0, IDX_PRESCALER, 8'h00, 8'h00}, {1'b1, IDX_BIT_LEN, 8'h21, 8'h00},
    {1'b1, IDX_IRQ_ENABLE, 8'h01, 8'h00}, {1'b1, IDX_REMOTE_LO, 8'hFF, 8'h00},
    {1'b0, IDX_REMOTE_LO, 8'h00, 8'h00}, {1'b0, IDX_TX_CANCEL_LO, 8'h00, 8'h00},
    {1'b0, 6'h3F, 8'h00, 8'h00}, {1'b0, IDX_RX_READY_LO, 8'h00, 8'h00},
    {1'b0, IDX_TX_SET_HI, 8'h00, 8'h00}};

  always #25 clk = ~clk;

  can_msg_request_status_and_prescaler i_can_msg_request_status_and_prescaler (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(ben), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .rx_store_i(rx_st), .rx_obj_i(rx_obj), .remote_rx_i(rem), .remote_obj_i(rem_obj), .tx_done_i(done),
    .tx_start_o(start), .tx_obj_o(tx_obj), .tx_busy_o(busy), .sys_tick_o(stick), .bit_tick_o(btick),
    .irq_o(irq));

  can_engine_model i_can_engine_model (
    .core_clk_i(clk), .rst_n_i(rst_n), .tx_start_i(start), .tx_obj_i(tx_obj), .delay_i(dly),
    .tx_done_o(done), .hist_o(hist));

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] r);
    int t;
    @(posedge clk);
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    wr   <= w;
    rd   <= !w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0 && t < 50);
    if (t >= 50) chk("waitrequest", 16'(wreq), 16'h0);
    r = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, q);
    chk(nm, {8'h00, q}, {8'h00, e});
  endtask : rdc

  task automatic ev(input logic remote, input logic [3:0] o);
    @(posedge clk);
    rx_st   <= !remote;
    rem     <= remote;
    rx_obj  <= o;
    rem_obj <= o;
    @(posedge clk);
    rx_st <= 1'b0;
    rem   <= 1'b0;
  endtask : ev

  task automatic wirq(input logic v, input int lim);
    int t;
    t = 0;
    while (irq !== v && t < lim) begin
      @(posedge clk);
      t++;
    end
    chk("irq", 16'(irq), 16'(v));
  endtask : wirq

  task automatic per(input logic b, input logic [15:0] e);
    int t;
    t = 0;
    do begin @(posedge clk); t++; end while ((b ? btick : stick) !== 1'b1 && t < 500);
    t = 0;
    do begin @(posedge clk); t++; end while ((b ? btick : stick) !== 1'b1 && t < 500);
    chk(b ? "bit_period" : "sys_period", 16'(t), e);
  endtask : per

  task automatic idle();
    int t, s;
    t = 0;
    s = 0;
    while (s < 4 && t < 600) begin
      @(posedge clk);
      t++;
      s = (busy === 1'b0) ? s + 1 : 0;
    end
  endtask : idle

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  initial begin
    #2000000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      bus(ROWS[i][22], ROWS[i][21:16], ROWS[i][15:8], q);
      if (!ROWS[i][22]) chk("row", {8'h00, q}, {8'h00, ROWS[i][7:0]});
    end
    ben <= 4'h0;
    bus(1'b1, IDX_RX_MASK_LO, 8'h00, q);
    ben <= 4'h1;
    rdc("mask_be0", IDX_RX_MASK_LO, 8'hA5);
    per(1'b0, 16'd6);
    per(1'b1, 16'd36);
    bus(1'b1, IDX_MODE, 8'h00, q);
    bus(1'b1, IDX_PRESCALER, 8'h05, q);
    per(1'b0, 16'd6);
    ev(1'b0, 4'h1);
    repeat (5) @(posedge clk);
    chk("irq_masked", 16'(irq), 16'h0);
    ev(1'b0, 4'h2);
    wirq(1'b1, 4);
    bus(1'b1, IDX_RX_READY_LO, 8'hFF, q);
    rdc("ready_w1", IDX_RX_READY_LO, 8'h06);
    bus(1'b1, IDX_RX_READY_LO, 8'hFB, q);
    repeat (3) @(posedge clk);
    chk("irq_hold", 16'(irq), 16'h1);
    rdc("ready_w0", IDX_RX_READY_LO, 8'h02);
    wirq(1'b0, 200);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h00, q);
    ev(1'b0, 4'h7);
    repeat (5) @(posedge clk);
    chk("irq_off", 16'(irq), 16'h0);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h01, q);
    wirq(1'b1, 4);
    bus(1'b1, IDX_RX_READY_LO, 8'h00, q);
    wirq(1'b0, 200);
    ev(1'b0, 4'hC);
    rdc("ready_hi", IDX_RX_READY_HI, 8'h10);
    bus(1'b1, IDX_RX_READY_HI, 8'h00, q);
    wirq(1'b0, 200);
    dly <= 8'd40;
    ev(1'b1, 4'hA);
    rdc("remote_hi", IDX_REMOTE_HI, 8'h04);
    bus(1'b1, IDX_TX_SET_LO, 8'h09, q);
    bus(1'b1, IDX_TX_SET_HI, 8'h24, q);
    bus(1'b1, IDX_TX_SET_LO, 8'h00, q);
    rdc("set_lo_w0", IDX_TX_SET_LO, 8'h09);
    bus(1'b1, IDX_TX_CANCEL_LO, 8'h08, q);
    bus(1'b1, IDX_TX_CANCEL_HI, 8'h20, q);
    rdc("set_hi_cancel", IDX_TX_SET_HI, 8'h04);
    rdc("cancel_read", IDX_TX_CANCEL_HI, 8'h00);
    idle();
    chk("tx_order", hist, 16'h03A0);
    rdc("set_lo_done", IDX_TX_SET_LO, 8'h00);
    rdc("set_hi_done", IDX_TX_SET_HI, 8'h00);
    rdc("remote_done", IDX_REMOTE_HI, 8'h00);
    dly <= 8'd0;
    bus(1'b1, IDX_TX_SET_HI, 8'h80, q);
    idle();
    chk("tx_prompt", hist[3:0], 16'h000F);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc("mask_rst", IDX_RX_MASK_LO, 8'h00);
    rdc("mode_rst", IDX_MODE, 8'h01);
    stop_test();
  end
endmodule : can_msg_request_status_and_prescaler_bench
